// ===== hw/adc_out_ctrl_pkg.sv
// Purpose: Shared constants and types for the ADC output control block.
// Assumes: 8-bit register address, 8-bit register data, 16-bit serial frame.
// Notes: Software-reset and custom-word layout are fixed here.
package adc_out_ctrl_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] SW_RESET_ADDR = 8'h00;
	localparam int SW_RESET_BIT = 1;
	localparam logic [7:0] CUSTOM_LO_ADDR = 8'h51;
	localparam logic [7:0] CUSTOM_HI_ADDR = 8'h52;
	localparam logic [7:0] OFFSET_CTRL_ADDR = 8'h55;
	localparam int OFFSET_EN_BIT = 6;
	localparam logic [7:0] PATTERN_ADDR = 8'h62;
	localparam int PATTERN_LSB = 0;
	localparam int PATTERN_W = 3;
	localparam logic [7:0] SHIFT_ADDR = 8'h63;
	localparam int SHIFT_LSB = 0;
	localparam int SHIFT_W = 6;
	localparam int CUSTOM_HI_W = 6;

	// ==========================================================
	// Reset values
	localparam logic [7:0] CUSTOM_LO_RST = 8'h00;
	localparam logic [7:0] CUSTOM_HI_RST = 8'h00;
	localparam logic [7:0] OFFSET_CTRL_RST = 8'h00;
	localparam logic [7:0] PATTERN_RST = 8'h00;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	localparam logic [3:0] PINS_RST = 4'h1;

	// ==========================================================
	// Serial frame and pattern timing
	localparam int FRAME_BITS = 16;
	localparam int ADDR_W = 8;
	localparam int REG_W = 8;
	localparam int RAMP_DIV_12BIT = 4;
	localparam int RAMP_DIV_14BIT = 1;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		pat_normal = 3'h0,
		pat_zeros = 3'h1,
		pat_ones = 3'h2,
		pat_toggle = 3'h3,
		pat_ramp = 3'h4,
		pat_custom = 3'h5,
		pat_unused6 = 3'h6,
		pat_unused7 = 3'h7
	} pattern_type;

	typedef enum logic [2:0] {
		ser_idle = 3'b001,
		ser_shift = 3'b010,
		ser_done = 3'b100
	} ser_state_type;

	typedef struct packed {
		logic reset_pin;
		logic sclk;
		logic serial_data_in;
		logic serial_select_in;
	} cfg_pins_type;

endpackage

// ===== hw/sample_fifo.sv
// Purpose: Small FIFO between the output word generator and the capture side.
// Assumes: Single clock; DEPTH a power of two.
// Notes: Read data and both ready/valid flags come from flip-flops.
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 4
) (
	input wire logic clk, // Clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic [WIDTH-1:0] in_data, // Word to store
	input wire logic in_valid, // Word offered
	output logic in_ready, // Room in storage
	output logic [WIDTH-1:0] out_data, // Head word
	output logic out_valid, // Head word present
	input wire logic out_ready // Drain side takes the head
);
	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("sample_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = (count != '0) && (!out_valid || out_ready);

	// ==========================================================
	// Storage
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// ==========================================================
	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
			in_ready <= (count + (PW+1)'(push) - (PW+1)'(pop)) < (PW+1)'(DEPTH);
		end
	end

	// ==========================================================
	// Output register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			out_data <= '0;
			out_valid <= 1'b0;
		end else if (pop) begin
			out_data <= mem[rd_ptr];
			out_valid <= 1'b1;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule

// ===== hw/adc_out_ctrl.sv
// Purpose: Output-side control of the converter: test patterns, level shift, config port.
// Assumes: Samples arrive on clk with a valid strobe; config pins are asynchronous.
// Notes: Serial frames are 8 address bits then 8 data bits, MSB first.
`timescale 1ns/1ps

// Behaviour
// - Pattern code 000 passes samples, 001 forces all zeros, 010 forces all ones.
// - Code 011 on 14 bits alternates 10101010101010 and 01010101010101 each sample.
// - Code 011 on 12 bits alternates 101010101010 and 010101010101 each sample.
// - Code 100 on 14 bits ramps by one every sample from 0 to 16383 and wraps.
// - Code 100 on 12 bits ramps by one every fourth sample from 0 to 4095.
// - Code 101 drives the custom word held in registers 0x51 and 0x52.
// - With correction on, the loop steers output under codes 000, 110 and 111 to mid-code plus the level shift.
// - The six-bit shift in 0x63 is a signed count from +31 to -32 LSB.
// - Shift 000000 converges on mid-code and 111111 one LSB below it.
// - The data pin is serial data while reset is low and power-down while reset is high.
// - The serial clock pin shifts the configuration port.
// - The shift acts only while bit 6 of 0x55 is set; clearing it stops the loop.
module adc_out_ctrl
	import adc_out_ctrl_pkg::*;
#(
	parameter int DATA_W = 14,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk, // 40 MHz clock
	input wire logic nrst, // Synchronous reset, active low
	input wire cfg_pins_type cfg_pins, // Asynchronous config pins
	input wire logic [DATA_W-1:0] conv_data, // Converted sample, offset binary
	input wire logic conv_valid, // Sample present
	output logic conv_ready, // Sample accepted when valid
	output logic [DATA_W-1:0] out_data, // Output word
	output logic out_valid, // Output word present
	input wire logic out_ready, // Capture side takes word
	output logic power_down, // Pin-control power-down level
	output logic clk_edge_ctrl // Pin-control output clock edge level
);
	localparam int RAMP_DIV = (DATA_W == 12) ? RAMP_DIV_12BIT : RAMP_DIV_14BIT;
	localparam int CW = DATA_W + 2;
	localparam logic signed [CW-1:0] MID = CW'(1 << (DATA_W - 1));
	localparam logic signed [CW-1:0] MAX_CODE = CW'((1 << DATA_W) - 1);
	localparam logic [DATA_W-1:0] TOGGLE_A = DATA_W'({(DATA_W / 2){2'b10}});

	// ==========================================================
	// Parameter checks
	if (DATA_W != 12 && DATA_W != 14) begin : g_bad_width
		$error("adc_out_ctrl: DATA_W must be 12 or 14");
	end
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("adc_out_ctrl: FIFO_DEPTH must be a power of two, at least 2");
	end
	if (RAMP_DIV < 1 || RAMP_DIV > 4) begin : g_bad_div
		$error("adc_out_ctrl: ramp divider must fit the two-bit counter");
	end

	// ==========================================================
	// Pin synchronisers
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	cfg_pins_type pin_f;
	cfg_pins_type pin_prev;
	logic sclk_rise;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			// Pins come out of reset at their idle levels
			pin_s1 <= PINS_RST;
			pin_s2 <= PINS_RST;
			pin_s3 <= PINS_RST;
		end else begin
			pin_s1 <= cfg_pins;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// A level counts once the second and third stages agree
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pin_f <= PINS_RST;
			pin_prev <= PINS_RST;
		end else begin
			pin_f <= (pin_s2 == pin_s3) ? cfg_pins_type'(pin_s3) : pin_f;
			pin_prev <= pin_f;
		end
	end

	assign sclk_rise = pin_f.sclk && !pin_prev.sclk;

	// ==========================================================
	// Serial configuration port
	ser_state_type ser_state;
	logic [FRAME_BITS-1:0] shift_reg;
	logic [4:0] bit_cnt;
	logic frame_done;
	logic [FRAME_BITS-1:0] frame_word;
	logic serial_mode;

	assign serial_mode = !pin_f.reset_pin;
	assign frame_word = {shift_reg[FRAME_BITS-2:0], pin_f.serial_data_in};

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ser_state <= ser_idle;
			shift_reg <= '0;
			bit_cnt <= 5'h00;
			frame_done <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			case (ser_state)
				ser_idle: begin
					bit_cnt <= 5'h00;
					if (serial_mode && !pin_f.serial_select_in)
						ser_state <= ser_shift;
				end
				ser_shift: begin
					if (!serial_mode || pin_f.serial_select_in) begin
						ser_state <= ser_idle;
					end else if (sclk_rise) begin
						shift_reg <= frame_word;
						bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt == 5'(FRAME_BITS - 1)) begin
							frame_done <= 1'b1;
							ser_state <= ser_done;
						end
					end
				end
				ser_done: begin
					if (!serial_mode || pin_f.serial_select_in)
						ser_state <= ser_idle;
				end
				default: ser_state <= ser_idle;
			endcase
		end
	end

	// ==========================================================
	// Registers
	logic [REG_W-1:0] custom_lo;
	logic [CUSTOM_HI_W-1:0] custom_hi;
	logic offset_en;
	pattern_type pattern_sel;
	logic [SHIFT_W-1:0] level_shift;
	logic [ADDR_W-1:0] wr_addr;
	logic [REG_W-1:0] wr_data;
	logic soft_reset;
	logic clear_regs;

	assign wr_addr = shift_reg[FRAME_BITS-1:REG_W];
	assign wr_data = shift_reg[REG_W-1:0];
	assign soft_reset = frame_done && wr_addr == SW_RESET_ADDR && wr_data[SW_RESET_BIT];
	// Reset pin high clears the map, so a high pulse initialises it
	assign clear_regs = pin_f.reset_pin || soft_reset;

	// ==========================================================
	// Write decode
	logic wr_custom_lo;
	logic wr_custom_hi;
	logic wr_offset;
	logic wr_pattern;
	logic wr_shift;

	always_comb begin
		wr_custom_lo = 1'b0;
		wr_custom_hi = 1'b0;
		wr_offset = 1'b0;
		wr_pattern = 1'b0;
		wr_shift = 1'b0;
		if (frame_done) begin
			if (wr_addr == CUSTOM_LO_ADDR) begin
				wr_custom_lo = 1'b1;
			end else if (wr_addr == CUSTOM_HI_ADDR) begin
				wr_custom_hi = 1'b1;
			end else if (wr_addr == OFFSET_CTRL_ADDR) begin
				wr_offset = 1'b1;
			end else if (wr_addr == PATTERN_ADDR) begin
				wr_pattern = 1'b1;
			end else if (wr_addr == SHIFT_ADDR) begin
				wr_shift = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || clear_regs) begin
			custom_lo <= CUSTOM_LO_RST;
		end else if (wr_custom_lo) begin
			custom_lo <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || clear_regs) begin
			custom_hi <= CUSTOM_HI_RST[CUSTOM_HI_W-1:0];
		end else if (wr_custom_hi) begin
			custom_hi <= wr_data[CUSTOM_HI_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || clear_regs) begin
			offset_en <= OFFSET_CTRL_RST[OFFSET_EN_BIT];
		end else if (wr_offset) begin
			offset_en <= wr_data[OFFSET_EN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || clear_regs) begin
			pattern_sel <= pattern_type'(PATTERN_RST[PATTERN_LSB +: PATTERN_W]);
		end else if (wr_pattern) begin
			pattern_sel <= pattern_type'(wr_data[PATTERN_LSB +: PATTERN_W]);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || clear_regs) begin
			level_shift <= SHIFT_RST[SHIFT_LSB +: SHIFT_W];
		end else if (wr_shift) begin
			level_shift <= wr_data[SHIFT_LSB +: SHIFT_W];
		end
	end

	// ==========================================================
	// Pin-control levels
	always_ff @(posedge clk) begin
		if (!nrst || !pin_f.reset_pin) begin
			power_down <= 1'b0;
		end else begin
			power_down <= pin_f.serial_data_in;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !pin_f.reset_pin) begin
			clk_edge_ctrl <= 1'b0;
		end else begin
			clk_edge_ctrl <= pin_f.serial_select_in;
		end
	end

	// ==========================================================
	// Offset correction loop
	logic accept;
	logic fifo_ready;
	logic signed [CW-1:0] corr;
	logic signed [CW-1:0] target;
	logic signed [CW-1:0] corrected;
	logic [DATA_W-1:0] sample_word;

	assign accept = conv_valid && fifo_ready;
	// Signed shift added to mid-code
	assign target = MID + CW'(signed'(level_shift));
	assign corrected = signed'(CW'(conv_data)) - corr;

	always_comb begin
		if (!offset_en) begin
			sample_word = conv_data;
		end else if (corrected < 0) begin
			sample_word = '0;
		end else if (corrected > MAX_CODE) begin
			sample_word = MAX_CODE[DATA_W-1:0];
		end else begin
			sample_word = corrected[DATA_W-1:0];
		end
	end

	// One LSB step per sample towards the target level
	always_ff @(posedge clk) begin
		if (!nrst || !offset_en) begin
			corr <= '0;
		end else if (accept) begin
			if (corrected > target)
				corr <= corr + CW'(1);
			else if (corrected < target)
				corr <= corr - CW'(1);
		end
	end

	// ==========================================================
	// Pattern generators
	logic toggle_phase;
	logic [DATA_W-1:0] ramp;
	logic [1:0] ramp_div;

	always_ff @(posedge clk) begin
		if (!nrst || pattern_sel != pat_toggle) begin
			toggle_phase <= 1'b0;
		end else if (accept) begin
			toggle_phase <= !toggle_phase;
		end
	end

	logic ramp_step;

	assign ramp_step = accept && ramp_div == 2'(RAMP_DIV - 1);

	// Divider gives one ramp step per RAMP_DIV taken samples
	always_ff @(posedge clk) begin
		if (!nrst || pattern_sel != pat_ramp || ramp_step) begin
			ramp_div <= 2'h0;
		end else if (accept) begin
			ramp_div <= ramp_div + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || pattern_sel != pat_ramp) begin
			ramp <= '0;
		end else if (ramp_step) begin
			ramp <= ramp + 1'b1;
		end
	end

	// ==========================================================
	// Output word select
	logic [DATA_W-1:0] next_word;

	always_comb begin
		case (pattern_sel)
			pat_zeros: next_word = '0;
			pat_ones: next_word = '1;
			pat_toggle: next_word = toggle_phase ? ~TOGGLE_A : TOGGLE_A;
			pat_ramp: next_word = ramp;
			pat_custom: next_word = DATA_W'({custom_hi, custom_lo});
			default: next_word = sample_word;
		endcase
	end

	// ==========================================================
	// Output buffer
	sample_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_data(next_word),
		.in_valid(conv_valid),
		.in_ready(fifo_ready),
		.out_data(out_data),
		.out_valid(out_valid),
		.out_ready(out_ready)
	);

	assign conv_ready = fifo_ready;

endmodule

// ===== tb/adc_out_ctrl_asserts.sv
// Purpose: Port checks for adc_out_ctrl.
// Assumes: Pin filters settle within 8 clocks.
// Notes: Bound into every instance.
`timescale 1ns/1ps
module adc_out_ctrl_asserts
	import adc_out_ctrl_pkg::*;
#(
	parameter int DATA_W = 14
) (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire cfg_pins_type cfg_pins, // Config pins
	input wire logic [DATA_W-1:0] conv_data, // Sample in
	input wire logic conv_valid, // Sample offered
	input wire logic conv_ready, // Room for sample
	input wire logic [DATA_W-1:0] out_data, // Word out
	input wire logic out_valid, // Word present
	input wire logic out_ready, // Word taken
	input wire logic power_down, // Power-down level
	input wire logic clk_edge_ctrl // Clock-edge level
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Pin modes
	sequence pin_ctrl_held;
		(cfg_pins.reset_pin && $stable(cfg_pins)) [*8];
	endsequence
	sequence serial_held;
		(!cfg_pins.reset_pin) [*8];
	endsequence
	pd_follow_a: assert property (pin_ctrl_held |-> power_down == cfg_pins.serial_data_in)
		else $error("power_down does not follow data pin");
	edge_follow_a: assert property (pin_ctrl_held |-> clk_edge_ctrl == cfg_pins.serial_select_in)
		else $error("clk_edge_ctrl does not follow select pin");
	serial_quiet_a: assert property (serial_held |-> !power_down && !clk_edge_ctrl)
		else $error("pin controls active in serial mode");
	// ==========================================================
	// Stream
	out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("output word changed before taken");
	out_drop_a: assert property ($fell(out_valid) |-> $past(out_ready))
		else $error("output word dropped untaken");
	out_lat_a: assert property (conv_valid && conv_ready && !out_valid |-> ##[1:4] out_valid)
		else $error("taken sample did not reach output");
	full_stall_a: assert property ($fell(conv_ready) |-> out_valid)
		else $error("refused with output empty");
	reset_state_a: assert property ($rose(nrst) |-> !out_valid && !conv_ready ##[1:2] conv_ready)
		else $error("bad state after reset");
endmodule

bind adc_out_ctrl adc_out_ctrl_asserts #(.DATA_W(DATA_W)) i_adc_out_ctrl_asserts (
	.clk(clk), .nrst(nrst), .cfg_pins(cfg_pins), .conv_data(conv_data),
	.conv_valid(conv_valid), .conv_ready(conv_ready), .out_data(out_data),
	.out_valid(out_valid), .out_ready(out_ready), .power_down(power_down),
	.clk_edge_ctrl(clk_edge_ctrl)
);

// ===== tb/capture_model.sv
// Purpose: Capture side that takes words with random stalls.
// Assumes: A word is taken where valid and ready meet.
// Notes: stall holds ready low for buffer fill.
`timescale 1ns/1ps
module capture_model (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic stall, // Hold off takes
	output logic out_ready // Take the word
);
	int rnd = 32'h954b;
	initial out_ready = 1'b0;
	always @(negedge clk) begin
		out_ready <= nrst && !stall && (($random(rnd) & 3) != 0);
	end
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for adc_out_ctrl.
// Assumes: 14-bit build; serial bits 200 ns.
// Notes: Expected words queue up as samples are taken.
`timescale 1ns/1ps
module tb;
	import adc_out_ctrl_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic stall = 1'b0;
	logic conv_valid = 1'b0;
	logic [13:0] conv_data = 14'h0;
	cfg_pins_type pins = 4'h1;
	logic conv_ready, out_valid, out_ready, power_down, clk_edge_ctrl;
	logic [13:0] out_data, d, cust;
	logic [14:0] e;
	logic [14:0] exp_q[$];
	logic [5:0] shifts[4] = '{6'h3f, 6'h1f, 6'h20, 6'h00};
	int err_count = 0;
	int num_checks = 0;
	int seed = 32'h954b;
	int i, k, n;
	always #12.5 clk = ~clk;
	adc_out_ctrl #(.DATA_W(14), .FIFO_DEPTH(4)) i_adc_out_ctrl (.clk(clk), .nrst(nrst),
		.cfg_pins(pins), .conv_data(conv_data), .conv_valid(conv_valid),
		.conv_ready(conv_ready), .out_data(out_data), .out_valid(out_valid),
		.out_ready(out_ready), .power_down(power_down), .clk_edge_ctrl(clk_edge_ctrl));
	capture_model i_capture_model (.clk(clk), .nrst(nrst), .stall(stall), .out_ready(out_ready));
	// ==========================================================
	// Tasks
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task check_val(input string what, input logic [13:0] ev, input logic [13:0] g);
		num_checks++;
		if (g !== ev) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, ev, g);
		end
	endtask
	task cyc(input int c);
		repeat (c) @(negedge clk);
	endtask
	task send(input logic [13:0] v, input logic [14:0] ev);
		int w;
		w = 0;
		conv_data = v;
		conv_valid = 1'b1;
		@(posedge clk);
		while (conv_ready !== 1'b1 && w < 300) begin
			w++;
			@(posedge clk);
		end
		if (conv_ready !== 1'b1) begin
			check_val("conv_ready", 14'h1, 14'h0);
			stop_test;
		end
		exp_q.push_back(ev);
		@(negedge clk);
	endtask
	task drain;
		int w;
		w = 0;
		conv_valid = 1'b0;
		while (exp_q.size() != 0 && w < 3000) begin
			w++;
			@(negedge clk);
		end
		if (exp_q.size() != 0) begin
			check_val("queue empty", 14'h0, 14'h1);
			stop_test;
		end
		cyc(2);
	endtask
	task ser_write(input logic [7:0] a, input logic [7:0] v);
		logic [15:0] f;
		f = {a, v};
		pins.serial_select_in = 1'b0;
		cyc(4);
		for (int b = 15; b >= 0; b--) begin
			pins.sclk = 1'b0;
			pins.serial_data_in = f[b];
			cyc(4);
			pins.sclk = 1'b1;
			cyc(4);
		end
		pins.sclk = 1'b0;
		cyc(4);
		pins.serial_select_in = 1'b1;
		pins.serial_data_in = ~f[0];
		cyc(12);
	endtask
	function automatic logic [13:0] pat(input int c, input int j, input logic [13:0] v);
		case (c)
			1: return 14'h0;
			2: return 14'h3fff;
			3: return j[0] ? 14'h1555 : 14'h2aaa;
			4: return j[13:0];
			5: return cust;
			default: return v;
		endcase
	endfunction
	// ==========================================================
	// Output monitor
	always @(posedge clk) begin
		if (nrst && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check_val("out_valid", 14'h0, 14'h1);
			end else begin
				e = exp_q.pop_front();
				if (!e[14]) begin
					check_val("out_data", e[13:0], out_data);
				end
			end
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		cyc(2);
		pins = 4'ha;
		cyc(12);
		check_val("power_down", 14'h1, {13'h0, power_down});
		check_val("clk_edge_ctrl", 14'h0, {13'h0, clk_edge_ctrl});
		pins = 4'h9;
		cyc(12);
		check_val("power_down", 14'h0, {13'h0, power_down});
		check_val("clk_edge_ctrl", 14'h1, {13'h0, clk_edge_ctrl});
		pins = 4'h1;
		cyc(12);
		check_val("power_down", 14'h0, {13'h0, power_down});
		$display("pin control done");
		cust = $random(seed);
		ser_write(CUSTOM_LO_ADDR, cust[7:0]);
		ser_write(CUSTOM_HI_ADDR, {2'b00, cust[13:8]});
		for (k = 0; k < 8; k++) begin
			ser_write(PATTERN_ADDR, k[7:0]);
			n = (k == 4) ? 16386 : 6;
			for (i = 0; i < n; i++) begin
				d = $random(seed);
				send(d, {1'b0, pat(k, i, d)});
			end
			drain;
			$display("pattern %0d done", k);
		end
		ser_write(PATTERN_ADDR, 8'h02);
		ser_write(SHIFT_ADDR, 8'h1f);
		ser_write(OFFSET_CTRL_ADDR, 8'(1 << OFFSET_EN_BIT));
		ser_write(SW_RESET_ADDR, 8'(1 << SW_RESET_BIT));
		for (i = 0; i < 4; i++) begin
			d = $random(seed);
			send(d, {1'b0, d});
		end
		drain;
		$display("soft reset done");
		ser_write(OFFSET_CTRL_ADDR, 8'(1 << OFFSET_EN_BIT));
		for (k = 0; k < 4; k++) begin
			ser_write(SHIFT_ADDR, {2'b00, shifts[k]});
			for (i = 0; i < 80; i++) begin
				send(14'h2000, {i < 72, 14'h2000 + {{8{shifts[k][5]}}, shifts[k]}});
			end
			drain;
		end
		ser_write(SHIFT_ADDR, 8'h1f);
		ser_write(OFFSET_CTRL_ADDR, 8'h00);
		for (i = 0; i < 4; i++) begin
			d = $random(seed);
			send(d, {1'b0, d});
		end
		drain;
		$display("level shift done");
		stall = 1'b1;
		cyc(2);
		n = 0;
		conv_valid = 1'b1;
		for (i = 0; i < 20; i++) begin
			d = $random(seed);
			conv_data = d;
			@(posedge clk);
			if (conv_ready === 1'b1) begin
				n++;
				exp_q.push_back({1'b0, d});
			end
			@(negedge clk);
		end
		check_val("words taken", 14'h5, n[13:0]);
		stall = 1'b0;
		drain;
		$display("buffer fill done");
		stop_test;
	end
endmodule
